/* rtl/bld_dimming.sv */
// frame-synchronised pwm dimming timing with ahb-lite register slave
`timescale 1ns/100ps
`include "bld_params.svh"

module bld_dimming (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        vsync,
  output logic [15:0]      pwm_out
);
  localparam int NCH = `BLD_CH;

  bld_pkg::bld_state_t st_q;
  logic [15:0]         st_cnt_q;
  logic                mode_q;      // 0 local dimming, 1 scanning
  logic [1:0]          mdl_q;
  logic [4:0]          freq_q;
  logic [4:0]          duty_q;
  logic [11:0]         addr_q;
  logic                addr_ok_q;
  logic                wr_q;
  logic                rd_q;
  logic                hready_q;
  logic [31:0]         hrdata_q;
  logic [19:0]         delay_q   [NCH];
  logic [11:0]         bright_q  [NCH];
  bld_pkg::bld_ton_t   next_on_q [NCH];
  bld_pkg::bld_ton_t   act_on_q  [NCH];
  logic [7:0]          win_left_q[NCH];
  logic [15:0]         calc_pend_q;
  logic [15:0]         fresh_q;
  logic [15:0]         armed_q;
  logic [15:0]         apply_q;
  logic [3:0]          calc_ch_q;
  logic                issued_q;
  logic                vsync_q;
  logic [23:0]         frame_cnt_q;
  logic [23:0]         vs_per_q;
  logic [15:0]         ph_q;
  logic                scan_busy_q;
  logic [31:0]         scan_acc_q;
  logic [31:0]         scan_tgt_q;
  logic [7:0]          scan_cnt_q;
  logic [7:0]          scan_n_q;
  logic [15:0]         pwm_q;

  function automatic logic [15:0] tdim_of(input logic [4:0] f);
    tdim_of = 16'(({11'h0, f} + 16'h1) * `BLD_TDIM_STEP);
  endfunction : tdim_of

  function automatic logic pwm_level(input logic [1:0] m, input logic [15:0] ph,
                                     input logic [15:0] td, input logic [15:0] on);
    logic [15:0] off;
    logic [15:0] lead;
    off  = td - on;
    lead = {1'b0, off[15:1]};
    if (m == bld_pkg::BLD_MDL_TRAIL)
      pwm_level = (ph >= off);
    else if (m == bld_pkg::BLD_MDL_CENTER)
      pwm_level = (ph >= lead) && (ph < lead + on);
    else
      pwm_level = (ph < on);
  endfunction : pwm_level

  // bus decode
  wire         addr_phase = hsel && hready && htrans[1];
  wire         wr_ctrl    = wr_q && addr_ok_q && (addr_q == `BLD_CTRL_OFS);
  wire         wr_dly     = wr_q && addr_ok_q && (addr_q[11:6] == `BLD_DLY_PAGE);
  wire         wr_dim     = wr_q && addr_ok_q && (addr_q[11:6] == `BLD_DIM_PAGE);
  wire [3:0]   reg_idx    = addr_q[5:2];
  wire [15:0]  tdim       = tdim_of(freq_q);
  wire         vs_rise    = vsync && !vsync_q;
  wire         ph_wrap    = (ph_q >= tdim - 16'h1);
  wire         run        = (st_q == bld_pkg::BLD_ST_RUN);
  wire [6:0]   duty_pct   = (duty_q > `BLD_DUTY_MAX_CODE) ? 7'h64
                          : 7'(7'h14 + {duty_q, 2'b00});
  wire [31:0]  tdim_x100  = 32'(tdim) * 32'h64;
  wire         calc_done;
  bld_pkg::bld_ton_t calc_on;
  logic [3:0]  pick;
  logic        pick_ok;
  logic [31:0] rdata_w;

  // lowest pending channel goes to the calculator first
  always_comb begin
    pick    = 4'h0;
    pick_ok = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (calc_pend_q[i]) begin
        pick    = 4'(i);
        pick_ok = 1'b1;
      end
    end
  end
  wire calc_start = pick_ok && !issued_q;

  always_comb begin
    if (!addr_ok_q)
      rdata_w = 32'h0;
    else if (addr_q == `BLD_CTRL_OFS)
      rdata_w = {15'h0, duty_q, 3'h0, freq_q, 1'b0, mdl_q, mode_q};
    else if (addr_q == `BLD_STAT_OFS)
      rdata_w = {28'h0, scan_busy_q, issued_q | pick_ok,
                 st_q == bld_pkg::BLD_ST_RUN, st_q != bld_pkg::BLD_ST_INIT};
    else if (addr_q == `BLD_VSPER_OFS)
      rdata_w = {8'h0, vs_per_q};
    else if (addr_q == `BLD_SCANN_OFS)
      rdata_w = {24'h0, scan_n_q};
    else if (addr_q[11:6] == `BLD_DLY_PAGE)
      rdata_w = {12'h0, delay_q[reg_idx]};
    else if (addr_q[11:6] == `BLD_DIM_PAGE)
      rdata_w = {20'h0, bright_q[reg_idx]};
    else
      rdata_w = 32'h0;
  end

  // ahb-lite slave: writes zero-wait, reads one wait state so data is fresh
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q    <= 12'h0;
      addr_ok_q <= 1'b0;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      hready_q  <= 1'b1;
      hrdata_q  <= 32'h0;
    end else begin
      wr_q     <= addr_phase && hwrite;
      rd_q     <= addr_phase && !hwrite;
      hready_q <= !(addr_phase && !hwrite);
      if (addr_phase) begin
        addr_q    <= haddr[11:0];
        addr_ok_q <= (haddr[31:12] == 20'h0) && (haddr[1:0] == 2'b00);
      end
      if (rd_q)
        hrdata_q <= rdata_w;
    end
  end

  // init, wait for control write, calibrate, run
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= bld_pkg::BLD_ST_INIT;
      st_cnt_q <= 16'h0;
      mode_q   <= 1'b0;
      mdl_q    <= 2'h0;
      freq_q   <= 5'h0;
      duty_q   <= 5'h0;
    end else begin
      if (wr_ctrl) begin
        mode_q <= hwdata[`BLD_CTRL_MODE_BIT];
        mdl_q  <= (hwdata[`BLD_CTRL_MDL_LSB +: 2] == 2'h3) ? 2'h0
                : hwdata[`BLD_CTRL_MDL_LSB +: 2];
        freq_q <= hwdata[`BLD_CTRL_FREQ_LSB +: 5];
        duty_q <= hwdata[`BLD_CTRL_DUTY_LSB +: 5];
      end
      case (st_q)
        bld_pkg::BLD_ST_INIT: begin
          st_cnt_q <= st_cnt_q + 16'h1;
          if (st_cnt_q == 16'(`BLD_INIT_CYCLES - 1)) begin
            st_q     <= bld_pkg::BLD_ST_CFG;
            st_cnt_q <= 16'h0;
          end
        end
        bld_pkg::BLD_ST_CFG: begin
          if (wr_ctrl)
            st_q <= bld_pkg::BLD_ST_CALI;
        end
        bld_pkg::BLD_ST_CALI: begin
          st_cnt_q <= st_cnt_q + 16'h1;
          if (st_cnt_q == 16'(`BLD_CALI_CYCLES - 1))
            st_q <= bld_pkg::BLD_ST_RUN;
        end
        default: st_q <= bld_pkg::BLD_ST_RUN;
      endcase
    end
  end

  // frame timing, scan period rounding to whole dimming periods
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vsync_q     <= 1'b0;
      frame_cnt_q <= 24'h0;
      vs_per_q    <= 24'h0;
      ph_q        <= 16'h0;
      scan_busy_q <= 1'b0;
      scan_acc_q  <= 32'h0;
      scan_tgt_q  <= 32'h0;
      scan_cnt_q  <= 8'h0;
      scan_n_q    <= 8'h1;
    end else begin
      vsync_q     <= vsync;
      frame_cnt_q <= vs_rise ? 24'h0
                   : (frame_cnt_q == 24'hFFFFFF) ? frame_cnt_q : frame_cnt_q + 24'h1;
      ph_q        <= (vs_rise || ph_wrap) ? 16'h0 : ph_q + 16'h1;
      if (vs_rise) begin
        vs_per_q    <= frame_cnt_q;
        scan_busy_q <= 1'b1;
        // frame counter stops one short of the true period, so add it back
        scan_tgt_q  <= 32'(duty_pct) * (32'(frame_cnt_q) + 32'h1);
        scan_acc_q  <= 32'(tdim) * 32'h32;
        scan_cnt_q  <= 8'h0;
      end else if (scan_busy_q) begin
        // counts periods while the half-period-biased sum stays at or under target
        if (scan_acc_q <= scan_tgt_q && scan_cnt_q != 8'hFF) begin
          scan_acc_q <= scan_acc_q + tdim_x100;
          scan_cnt_q <= scan_cnt_q + 8'h1;
        end else begin
          scan_busy_q <= 1'b0;
          scan_n_q    <= (scan_cnt_q == 8'h0) ? 8'h1 : scan_cnt_q;
        end
      end
    end
  end

  // brightness writes queue calculations while the host keeps writing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      calc_pend_q <= 16'h0;
      calc_ch_q   <= 4'h0;
      issued_q    <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_dim && reg_idx == 4'(i))
          calc_pend_q[i] <= 1'b1;
        else if (calc_start && pick == 4'(i))
          calc_pend_q[i] <= 1'b0;
      end
      if (calc_start) begin
        calc_ch_q <= pick;
        issued_q  <= 1'b1;
      end else if (calc_done) begin
        issued_q <= 1'b0;
      end
    end
  end

  bld_ontime_calc u_calc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (calc_start),
    .bright  (bright_q[pick]),
    .tdim    (tdim),
    .done    (calc_done),
    .ontime  (calc_on)
  );

  // per-channel registers, buffering and apply at group delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fresh_q <= 16'h0;
      armed_q <= 16'h0;
      apply_q <= 16'h0;
      pwm_q   <= 16'h0;
      for (int i = 0; i < NCH; i++) begin
        delay_q[i]    <= 20'h0;
        bright_q[i]   <= 12'h0;
        next_on_q[i]  <= 16'h0;
        act_on_q[i]   <= 16'h0;
        win_left_q[i] <= 8'h0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_dly && reg_idx == 4'(i))
          delay_q[i] <= hwdata[19:0];
        if (wr_dim && reg_idx == 4'(i))
          bright_q[i] <= hwdata[11:0];
        if (calc_done && calc_ch_q == 4'(i)) begin
          next_on_q[i] <= calc_on;
          fresh_q[i]   <= 1'b1;
        end else if (vs_rise) begin
          fresh_q[i]   <= 1'b0;
        end
        // values finished in frame n are armed at the next vsync only
        if (vs_rise)
          armed_q[i] <= fresh_q[i] | armed_q[i];
        else if (apply_q[i] && ph_wrap)
          armed_q[i] <= 1'b0;
        if (armed_q[i] && !vs_rise && frame_cnt_q == 24'(delay_q[i]))
          apply_q[i] <= 1'b1;
        else if (apply_q[i] && ph_wrap)
          apply_q[i] <= 1'b0;
        if (apply_q[i] && ph_wrap) begin
          act_on_q[i]   <= next_on_q[i];
          win_left_q[i] <= scan_n_q;
        end else if (ph_wrap && win_left_q[i] != 8'h0) begin
          win_left_q[i] <= win_left_q[i] - 8'h1;
        end
        pwm_q[i] <= run && pwm_level(mdl_q, ph_q, tdim, act_on_q[i])
                    && (!mode_q || win_left_q[i] != 8'h0);
      end
    end
  end

  assign hreadyout = hready_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign pwm_out   = pwm_q;
endmodule : bld_dimming

/* rtl/bld_params.svh */
// constants for the backlight dimming timing block
`ifndef BLD_PARAMS_SVH
`define BLD_PARAMS_SVH

`define BLD_CLK_PERIOD_NS 20
`define BLD_INIT_TIME_NS  2000
`define BLD_INIT_CYCLES   ((`BLD_INIT_TIME_NS + `BLD_CLK_PERIOD_NS - 1) / `BLD_CLK_PERIOD_NS)
`define BLD_CALI_TIME_NS  4000
`define BLD_CALI_CYCLES   ((`BLD_CALI_TIME_NS + `BLD_CLK_PERIOD_NS - 1) / `BLD_CLK_PERIOD_NS)

`define BLD_CH            16
`define BLD_TDIM_STEP     16'h0040
`define BLD_BRIGHT_BITS   12
`define BLD_DUTY_MAX_CODE 5'h14

`define BLD_CTRL_OFS      12'h000
`define BLD_STAT_OFS      12'h004
`define BLD_VSPER_OFS     12'h008
`define BLD_SCANN_OFS     12'h00C
`define BLD_DLY_PAGE      6'h01
`define BLD_DIM_PAGE      6'h02

`define BLD_CTRL_MODE_BIT 0
`define BLD_CTRL_MDL_LSB  1
`define BLD_CTRL_FREQ_LSB 4
`define BLD_CTRL_DUTY_LSB 12

`define BLD_STAT_INIT_BIT 0
`define BLD_STAT_CALI_BIT 1
`define BLD_STAT_CALC_BIT 2
`define BLD_STAT_SCAN_BIT 3

`endif

/* rtl/bld_pkg.sv */
// types shared by the backlight dimming timing block
package bld_pkg;
  typedef enum logic [3:0] {
    BLD_ST_INIT = 4'h1,
    BLD_ST_CFG  = 4'h2,
    BLD_ST_CALI = 4'h4,
    BLD_ST_RUN  = 4'h8
  } bld_state_t;

  typedef enum logic [1:0] {
    BLD_MDL_LEAD   = 2'h0,
    BLD_MDL_TRAIL  = 2'h1,
    BLD_MDL_CENTER = 2'h2
  } bld_mdl_t;

  typedef logic [15:0] bld_ton_t;
endpackage : bld_pkg

/* rtl/bld_ontime_calc.sv */
// serial shift-add on-time calculator: ontime = bright * tdim / 4096
`timescale 1ns/100ps
module bld_ontime_calc (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          start,
  input  wire logic [11:0]   bright,
  input  wire logic [15:0]   tdim,
  output logic               done,
  output bld_pkg::bld_ton_t  ontime
);
  logic [27:0] acc_q;
  logic [27:0] mcand_q;
  logic [11:0] mplier_q;
  logic [3:0]  cnt_q;
  logic        run_q;
  logic        done_q;

  // twelve cycles per channel keeps area tiny; host writes are far slower
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q    <= 28'h0;
      mcand_q  <= 28'h0;
      mplier_q <= 12'h0;
      cnt_q    <= 4'h0;
      run_q    <= 1'b0;
      done_q   <= 1'b0;
    end else if (start) begin
      acc_q    <= 28'h0;
      mcand_q  <= {12'h0, tdim};
      mplier_q <= bright;
      cnt_q    <= 4'hC;
      run_q    <= 1'b1;
      done_q   <= 1'b0;
    end else if (run_q) begin
      acc_q    <= mplier_q[0] ? acc_q + mcand_q : acc_q;
      mcand_q  <= {mcand_q[26:0], 1'b0};
      mplier_q <= {1'b0, mplier_q[11:1]};
      cnt_q    <= cnt_q - 4'h1;
      run_q    <= (cnt_q != 4'h1);
      done_q   <= (cnt_q == 4'h1);
    end else begin
      done_q   <= 1'b0;
    end
  end

  assign done   = done_q;
  assign ontime = acc_q[27:12];
endmodule : bld_ontime_calc

/* bench/bld_dimming_sva.sv */
// bus and output checks for the dimming timing block
`timescale 1ns/100ps
module bld_dimming_sva (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] pwm_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire  take = hsel & hready & htrans[1];
  logic rd1_q;
  logic rd2_q;
  logic [7:0] age_q;
  // age saturates so a long run never wraps back into the dark window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd1_q <= 1'b0;
      rd2_q <= 1'b0;
      age_q <= 8'h00;
    end else begin
      rd1_q <= take & ~hwrite;
      rd2_q <= rd1_q;
      age_q <= (age_q == 8'hFF) ? age_q : age_q + 8'h01;
    end
  end
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_idle; hready && !(hsel && htrans[1]) |=> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("idle stalled");
  property p_single; !hreadyout |=> hreadyout; endproperty
  a_single: assert property (p_single) else $error("two wait states");
  property p_unmapped; take && !hwrite && haddr[31:12] != 20'h0 |-> ##2 hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_hold; !rd2_q |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_dark; age_q < 8'h64 |-> pwm_out == 16'h0000; endproperty
  a_dark: assert property (p_dark) else $error("output lit before run");
  c_wr: cover property (take && hwrite);
  c_rd: cover property (take && !hwrite);
  c_lit: cover property (pwm_out != 16'h0000);
endmodule : bld_dimming_sva
bind bld_dimming bld_dimming_sva u_sva (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .pwm_out);

/* bench/bld_vsync_src.sv */
// frame sync source standing in for the host timing controller
`timescale 1ns/100ps
module bld_vsync_src #(
  parameter int PERIOD = 1000
) (
  input  wire logic sys_clk,
  input  wire logic en,
  output logic      vsync
);
  int cnt_q = 0;
  initial vsync = 1'b0;
  // one-cycle pulse per frame, quiet while disabled
  always @(posedge sys_clk) begin
    cnt_q <= (!en || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    vsync <= en && cnt_q == PERIOD - 1;
  end
endmodule : bld_vsync_src

/* bench/tb_bld_dimming.sv */
// self-checking bench for the dimming timing block
`timescale 1ns/100ps
module tb_bld_dimming;
  localparam int VSP = 1000;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        vs_en = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        vsync;
  logic [31:0] hrdata;
  logic [15:0] pwm_out;
  logic [31:0] rdat;
  int          err_total = 0;
  int          checks_done = 0;
  int          dc[4] = '{0, 2, 20, 25};
  int          du;
  always #10 sys_clk = ~sys_clk;
  bld_dimming uut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vsync, .pwm_out);
  bld_vsync_src #(.PERIOD(VSP)) u_vs (.sys_clk, .en(vs_en), .vsync);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("ERROR wait expected done seen timeout");
      report_and_stop();
    end
  endtask : hang
  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rdat = hrdata;
    hang(n, 40);
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask : rd
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      ahb(1'b0, 32'h4, 32'h0);
      n++;
    end while (rdat[b] !== 1'b1 && n < 200);
    hang(n, 200);
  endtask : poll
  task automatic wait_vs(input int gap);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (vsync !== 1'b1 && n < 2 * VSP);
    hang(n, 2 * VSP);
    repeat (gap) @(posedge sys_clk);
  endtask : wait_vs
  // a window of one whole period sees the on-time whatever its phase
  task automatic meas(input int ch, input int exp);
    int c;
    c = 0;
    repeat (64) begin
      @(posedge sys_clk);
      // an unknown level counts as lit so it can never pass as dark
      c += (pwm_out[ch] !== 1'b0);
    end
    chk("pwm_on", 32'(exp), 32'(c));
  endtask : meas
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    hsel    <= 1'b1;
    rd("status", 32'h4, 32'h0);
    poll(0);
    rd("status", 32'h4, 32'h1);
    wr(32'h0, 32'h4);
    poll(1);
    for (int m = 0; m < 4; m++) begin
      wr(32'h0, 32'(m << 1) | 32'h1F0);
      rd("ctrl", 32'h0, (m == 3) ? 32'h1F0 : 32'(m << 1) | 32'h1F0);
    end
    wr(32'h0, 32'h4);
    wr(32'h1000, 32'hFFFFFFFF);
    rd("unmapped", 32'h1000, 32'h0);
    rd("misaligned", 32'h2, 32'h0);
    for (int g = 0; g < 16; g++) begin
      wr(32'h40 + 32'(4 * g), 32'hFFFFFFFF);
      rd("delay", 32'h40 + 32'(4 * g), 32'h000FFFFF);
      wr(32'h40 + 32'(4 * g), 32'h0);
    end
    wr(32'h88, 32'hFFFFFFFF);
    rd("bright", 32'h88, 32'h00000FFF);
    vs_en <= 1'b1;
    wait_vs(0);
    wait_vs(100);
    rd("vs_period", 32'h8, 32'(VSP - 1));
    wr(32'h80, 32'h400);
    wr(32'h84, 32'h0);
    meas(0, 0);
    wait_vs(200);
    meas(0, 16);
    meas(1, 0);
    meas(2, 63);
    wait_vs(200);
    meas(0, 16);
    // expected scan length is duty times frame over period, rounded to nearest
    foreach (dc[i]) begin
      wr(32'h0, 32'(dc[i] << 12) | 32'h1);
      wait_vs(60);
      du = (dc[i] > 20) ? 100 : 20 + 4 * dc[i];
      rd("scan_len", 32'hC, 32'((2 * du * VSP + 6400) / 12800));
    end
    // at 20% duty a fresh value lights its group for three periods, then dark
    wr(32'h0, 32'h1);
    wr(32'h80, 32'h400);
    wait_vs(100);
    meas(0, 16);
    repeat (100) @(posedge sys_clk);
    meas(0, 0);
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    hang(1, 1);
  end
endmodule : tb_bld_dimming
